// File: hdl/mba_pkg.sv
// package for the multiprocessor bus arbitration and host acknowledge block
// assumes one 20 MHz clock shared by every processor on the bus
package mba_pkg;
   localparam int unsigned     CLK_PERIOD_NS   = 50;
   localparam int unsigned     NUM_BR          = 6;
   localparam int unsigned     ID_W            = 3;
   localparam logic [2:0]      ID_SINGLE       = 3'h0;
   localparam logic [2:0]      ID_MAX          = 3'h6;
   localparam logic [5:0]      BR_NONE         = 6'h00;
   // core priority pull-up in ohms, used only as documentation of the pad
   localparam int unsigned     CPA_PULLUP_OHM  = 5000;

   typedef enum logic [1:0] {
      MBA_IDLE,
      MBA_MASTER,
      MBA_HOST
   } mba_state_type;

   // host access group
   typedef struct packed {
      logic cs_n;
      logic hbr_n;
      logic busy;
   } mba_host_req_type;

   // tri-state pin pair
   typedef struct packed {
      logic o;
      logic oe;
   } mba_pin_type;
endpackage : mba_pkg

// File: hdl/mba_sync.sv
// two-flop synchroniser for a vector of pins
// assumes the inputs are asynchronous to core_clk_i
`timescale 1ns/100ps
module mba_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         core_clk_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] rst_val_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         meta_q <= rst_val_i;
         q_o    <= rst_val_i;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : mba_sync

// File: hdl/mba_arbiter.sv
// bus arbitration, host grant, core priority and host acknowledge of one processor
// assumes pins are asynchronous and resolved (wired-and) outside this module
`timescale 1ns/100ps
module mba_arbiter import mba_pkg::*; (
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   input  wire logic [ID_W-1:0]   processor_identifier_i,
   input  wire logic              arb_mode_strap_i,
   input  wire logic              ack_active_drive_cfg_i,
   input  wire logic              host_select_n_i,
   input  wire logic              host_bus_request_n_i,
   input  wire logic              host_access_busy_i,
   input  wire logic              bus_wanted_i,
   input  wire logic              core_wants_bus_i,
   input  wire logic              dma_active_i,
   input  wire logic [NUM_BR-1:0] mp_bus_request_lines_n_i,
   input  wire logic              core_priority_line_n_i,
   output logic [NUM_BR-1:0]      mp_bus_request_lines_o,
   output logic [NUM_BR-1:0]      mp_bus_request_lines_oe_o,
   output logic                   host_bus_grant_n_o,
   output logic                   host_bus_grant_n_oe_o,
   output logic                   host_access_ack_o,
   output logic                   host_access_ack_oe_o,
   output logic                   core_priority_line_o,
   output logic                   core_priority_line_oe_o,
   output logic                   is_master_o,
   output logic                   dma_hold_o,
   output logic                   single_proc_o
);
   // one-hot line for an identifier; zero and out-of-range give none
   function automatic logic [NUM_BR-1:0] id_line(input logic [ID_W-1:0] id);
      logic [NUM_BR-1:0] v;
      v = BR_NONE;
      if (id != ID_SINGLE && id <= ID_MAX) begin
         v = NUM_BR'(1) << (id - 3'h1);
      end
      return v;
   endfunction : id_line

   // winning line: lowest index at or after the start point, else the lowest index below it
   function automatic logic [NUM_BR-1:0] pick(input logic [NUM_BR-1:0] req,
                                             input logic [NUM_BR-1:0] start);
      logic [2*NUM_BR-1:0] dbl;
      logic [NUM_BR-1:0]   w;
      logic                found;
      int                  s;
      w     = BR_NONE;
      found = 1'b0;
      s     = 0;
      dbl   = {req, req};
      for (int i = 0; i < NUM_BR; i++) begin
         if (start[i]) begin
            s = i;
         end
      end
      for (int i = 0; i < 2*NUM_BR; i++) begin
         if (!found && i >= s && dbl[i]) begin
            found = 1'b1;
            w     = (i >= NUM_BR) ? NUM_BR'(1) << (i - NUM_BR) : NUM_BR'(1) << i;
         end
      end
      return w;
   endfunction : pick

   logic [NUM_BR-1:0] br_s;
   logic              hbr_s;
   logic              cs_s;
   logic              cpa_s;
   logic              strap_s;
   logic [ID_W-1:0]   id_meta_q;
   logic [ID_W-1:0]   id_q;
   logic [NUM_BR-1:0] own_line;
   logic [NUM_BR-1:0] req_all;
   logic [NUM_BR-1:0] start;
   logic [NUM_BR-1:0] winner;
   logic [NUM_BR-1:0] last_q;
   logic              want;
   mba_state_type     state_q;
   mba_pin_type       ack_d;

   mba_sync #(.W(NUM_BR + 4)) u_sync (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .rst_val_i  ({{NUM_BR{1'b1}}, 1'b1, 1'b1, 1'b1, 1'b0}),
      .d_i        ({mp_bus_request_lines_n_i, host_bus_request_n_i, host_select_n_i,
                    core_priority_line_n_i, arb_mode_strap_i}),
      .q_o        ({br_s, hbr_s, cs_s, cpa_s, strap_s})
   );

   // identifier captured while reset is held, so later pin changes are ignored;
   // two stages as for any pin, so reset must span at least two edges
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         id_meta_q <= processor_identifier_i;
         id_q      <= id_meta_q;
      end
   end

   assign own_line = id_line(id_q);
   assign want     = bus_wanted_i || core_wants_bus_i;
   // own request is seen back through the wire, so it has the same sync delay
   // as the other lines and cannot win before they are visible
   assign req_all  = ~br_s;
   // fixed: start at line one; rotating: start just past the last master
   assign start    = strap_s ? {last_q[NUM_BR-2:0], last_q[NUM_BR-1]}
                             : NUM_BR'(1);
   assign winner   = pick(req_all, start);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= MBA_IDLE;
      end else begin
         case (state_q)
            MBA_IDLE: begin
               if (!hbr_s) begin
                  state_q <= MBA_HOST;
               end else if (own_line != BR_NONE && want && winner == own_line) begin
                  state_q <= MBA_MASTER;
               end
            end
            MBA_MASTER: begin
               if (!hbr_s) begin
                  state_q <= MBA_HOST;
               end else if (!want) begin
                  state_q <= MBA_IDLE;
               end
            end
            MBA_HOST: begin
               if (hbr_s) begin
                  state_q <= MBA_IDLE;
               end
            end
            default: state_q <= MBA_IDLE;
         endcase
      end
   end

   // rotation pointer follows whichever line last won the bus
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         last_q <= NUM_BR'(1) << (NUM_BR - 1);
      end else if (winner != BR_NONE && hbr_s && (req_all & last_q) == BR_NONE) begin
         // pointer stays on a holder that still asks, so the pick cannot flip each cycle
         last_q <= winner;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mp_bus_request_lines_o    <= BR_NONE;
         mp_bus_request_lines_oe_o <= BR_NONE;
      end else begin
         // low on own line only; other lines never driven
         mp_bus_request_lines_o    <= BR_NONE;
         mp_bus_request_lines_oe_o <= (want && hbr_s) ? own_line : BR_NONE;
      end
   end

   // grant low until host lets go; driven by the master, by any processor in host state, and always by a lone processor
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         host_bus_grant_n_o    <= 1'b1;
         host_bus_grant_n_oe_o <= 1'b0;
      end else begin
         host_bus_grant_n_o    <= !(state_q == MBA_HOST && !hbr_s);
         host_bus_grant_n_oe_o <= state_q == MBA_MASTER || state_q == MBA_HOST
                                  || (own_line == BR_NONE);
      end
   end

   // slave core pulls the wired line; master holds DMA while anyone pulls it
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         core_priority_line_o    <= 1'b0;
         core_priority_line_oe_o <= 1'b0;
         dma_hold_o              <= 1'b0;
      end else begin
         core_priority_line_o    <= 1'b0;
         core_priority_line_oe_o <= core_wants_bus_i && state_q != MBA_MASTER;
         dma_hold_o              <= state_q == MBA_MASTER && !cpa_s && dma_active_i;
      end
   end

   always_comb begin
      ack_d.o  = !host_access_busy_i;
      ack_d.oe = 1'b0;
      if (!cs_s && !hbr_s) begin
         // open drain only pulls low; active drive also drives high
         ack_d.oe = host_access_busy_i || ack_active_drive_cfg_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         host_access_ack_o    <= 1'b1;
         host_access_ack_oe_o <= 1'b0;
      end else begin
         host_access_ack_o    <= ack_d.o;
         host_access_ack_oe_o <= ack_d.oe;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         is_master_o   <= 1'b0;
         single_proc_o <= 1'b0;
      end else begin
         is_master_o   <= state_q == MBA_MASTER;
         single_proc_o <= own_line == BR_NONE;
      end
   end
endmodule : mba_arbiter

// File: dv/mba_arbiter_monitor.sv
// checker on the pins of one arbiter
// assumes the identifier is held static outside reset
`timescale 1ns/100ps
module mba_arbiter_monitor import mba_pkg::*; (
   input wire logic              core_clk_i,
   input wire logic              srst_i,
   input wire logic [ID_W-1:0]   processor_identifier_i,
   input wire logic              ack_active_drive_cfg_i,
   input wire logic              host_access_busy_i,
   input wire logic              host_select_n_i,
   input wire logic              host_bus_request_n_i,
   input wire logic [NUM_BR-1:0] mp_bus_request_lines_oe_o,
   input wire logic              host_bus_grant_n_o,
   input wire logic              host_bus_grant_n_oe_o,
   input wire logic              host_access_ack_o,
   input wire logic              host_access_ack_oe_o,
   input wire logic              core_priority_line_o,
   input wire logic              core_priority_line_oe_o,
   input wire logic              single_proc_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   ack_wait_a: assert property (host_access_ack_oe_o && $past(host_access_busy_i) |-> !host_access_ack_o)
      else $error("ack high while busy");
   ack_drain_a: assert property ($fell(host_access_busy_i) && !ack_active_drive_cfg_i |=> !host_access_ack_oe_o)
      else $error("open drain ack drove high");
   ack_gate_a: assert property (host_access_ack_oe_o |-> !$past(host_select_n_i, 3) && !$past(host_bus_request_n_i, 3))
      else $error("ack driven without select");
   own_line_a: assert property (|mp_bus_request_lines_oe_o |-> mp_bus_request_lines_oe_o == 6'h01 << (processor_identifier_i - 3'h1))
      else $error("wrong request line");
   single_a: assert property (single_proc_o |-> mp_bus_request_lines_oe_o == BR_NONE)
      else $error("request in single mode");
   host_first_a: assert property ($fell(host_bus_request_n_i) ##1 !host_bus_request_n_i [*5] |-> !host_bus_grant_n_o && host_bus_grant_n_oe_o)
      else $error("host not granted");
   grant_hold_a: assert property (!host_bus_grant_n_o && host_bus_grant_n_oe_o && !host_bus_request_n_i |=> !host_bus_grant_n_o)
      else $error("grant dropped early");
   cpa_drain_a: assert property (core_priority_line_oe_o |-> !core_priority_line_o)
      else $error("priority line driven high");
   cover property (!host_bus_grant_n_o);
   cover property (host_access_ack_oe_o && !host_access_ack_o);
   cover property (|mp_bus_request_lines_oe_o);
endmodule : mba_arbiter_monitor
bind mba_arbiter mba_arbiter_monitor i_mon (.*);

// File: dv/mba_far_side.sv
// other processors and pull-ups on the shared wired lines
// assumes the bench commands what the other parties request
`timescale 1ns/100ps
module mba_far_side (
   input wire logic [5:0] dut_br_oe_i,
   input wire logic [5:0] other_br_i,
   input wire logic       dut_cpa_oe_i,
   input wire logic       other_cpa_i,
   output logic     [5:0] br_n_o,
   output logic           cpa_n_o
);
   // undriven lines rest at their pull-up, never at a stale level
   assign br_n_o = ~(dut_br_oe_i | other_br_i);
   assign cpa_n_o = ~(dut_cpa_oe_i | other_cpa_i);
endmodule : mba_far_side

// File: dv/test_multiproc_bus_arbitration_host_ack.sv
// bench for the arbiter of one processor
// assumes the far-side model resolves the bus request and core priority lines
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
module test_multiproc_bus_arbitration_host_ack import mba_pkg::*;;
   logic core_clk_i = 1'h0, srst_i = 1'h1, arb_mode_strap_i = 1'h0, ack_active_drive_cfg_i = 1'h0;
   logic host_select_n_i = 1'h1, host_bus_request_n_i = 1'h1, host_access_busy_i = 1'h0;
   logic bus_wanted_i = 1'h0, core_wants_bus_i = 1'h0, dma_active_i = 1'h0, other_cpa = 1'h0;
   logic [ID_W-1:0] processor_identifier_i = 3'h0;
   logic [NUM_BR-1:0] other_br = 6'h00, mp_bus_request_lines_n_i, mp_bus_request_lines_o;
   logic [NUM_BR-1:0] mp_bus_request_lines_oe_o;
   logic core_priority_line_n_i, host_bus_grant_n_o, host_bus_grant_n_oe_o, host_access_ack_o;
   logic host_access_ack_oe_o, core_priority_line_o, core_priority_line_oe_o, is_master_o;
   logic dma_hold_o, single_proc_o;
   int failures = 0, check_count = 0;
   mba_arbiter i_dut (.core_clk_i, .srst_i, .processor_identifier_i, .arb_mode_strap_i,
      .ack_active_drive_cfg_i, .host_select_n_i, .host_bus_request_n_i, .host_access_busy_i,
      .bus_wanted_i, .core_wants_bus_i, .dma_active_i, .mp_bus_request_lines_n_i,
      .core_priority_line_n_i, .mp_bus_request_lines_o, .mp_bus_request_lines_oe_o,
      .host_bus_grant_n_o, .host_bus_grant_n_oe_o, .host_access_ack_o, .host_access_ack_oe_o,
      .core_priority_line_o, .core_priority_line_oe_o, .is_master_o, .dma_hold_o, .single_proc_o);
   mba_far_side i_far (.dut_br_oe_i(mp_bus_request_lines_oe_o), .other_br_i(other_br),
      .dut_cpa_oe_i(core_priority_line_oe_o), .other_cpa_i(other_cpa),
      .br_n_o(mp_bus_request_lines_n_i), .cpa_n_o(core_priority_line_n_i));
   always #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
   // checks read the settled values that stand just before each edge
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : wt
   // the identifier and strap only change under reset, as the system must
   task automatic rst(input logic [2:0] id, input logic mode);
      srst_i <= 1'h1;
      processor_identifier_i <= id;
      arb_mode_strap_i <= mode;
      wt(6);
      srst_i <= 1'h0;
      wt(4);
   endtask : rst
   task automatic t_lines;
      for (int i = 0; i < 8; i++) begin
         rst(i[2:0], 1'h0);
         bus_wanted_i <= 1'h1;
         wt(8);
         `CHK("br_oe", (i == 0 || i == 7) ? BR_NONE : 6'h01 << (i - 1), mp_bus_request_lines_oe_o)
         `CHK("single", i == 0 || i == 7, single_proc_o)
         `CHK("br_val", BR_NONE, mp_bus_request_lines_o)
         bus_wanted_i <= 1'h0;
      end
   endtask : t_lines
   // line one wins first, then both ask together
   task automatic t_arb(input logic mode);
      rst(3'h2, mode);
      other_br <= 6'h01;
      wt(8);
      other_br <= 6'h00;
      wt(8);
      other_br <= 6'h01;
      bus_wanted_i <= 1'h1;
      wt(10);
      `CHK("master", mode, is_master_o)
      other_br <= 6'h00;
      bus_wanted_i <= 1'h0;
   endtask : t_arb
   task automatic t_host;
      rst(3'h1, 1'h0);
      bus_wanted_i <= 1'h1;
      wt(8);
      host_bus_request_n_i <= 1'h0;
      wt(8);
      `CHK("grant", 2'h2, {host_bus_grant_n_oe_o, host_bus_grant_n_o})
      wt(20);
      `CHK("held", 1'h0, host_bus_grant_n_o)
      host_bus_request_n_i <= 1'h1;
      wt(8);
      `CHK("release", 1'h1, host_bus_grant_n_o)
      bus_wanted_i <= 1'h0;
   endtask : t_host
   task automatic t_ack(input logic cfg);
      ack_active_drive_cfg_i <= cfg;
      host_bus_request_n_i <= 1'h0;
      host_access_busy_i <= 1'h1;
      wt(6);
      `CHK("no_cs", 1'h0, host_access_ack_oe_o)
      host_select_n_i <= 1'h0;
      wt(6);
      `CHK("ack_wait", 2'h2, {host_access_ack_oe_o, host_access_ack_o})
      host_access_busy_i <= 1'h0;
      wt(3);
      `CHK("ack_done", {cfg, 1'h1}, {host_access_ack_oe_o, host_access_ack_o})
      host_select_n_i <= 1'h1;
      host_bus_request_n_i <= 1'h1;
      wt(6);
      `CHK("ack_off", 1'h0, host_access_ack_oe_o)
   endtask : t_ack
   task automatic t_cpa;
      rst(3'h2, 1'h0);
      other_br <= 6'h01;
      core_wants_bus_i <= 1'h1;
      wt(8);
      `CHK("cpa_oe", 2'h2, {core_priority_line_oe_o, core_priority_line_o})
      other_br <= 6'h00;
      core_wants_bus_i <= 1'h0;
      bus_wanted_i <= 1'h1;
      dma_active_i <= 1'h1;
      wt(8);
      `CHK("dma_free", 1'h0, dma_hold_o)
      other_cpa <= 1'h1;
      wt(6);
      `CHK("dma_hold", 1'h1, dma_hold_o)
   endtask : t_cpa
   task automatic finish_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      wt(5000);
      failures++;
      finish_test;
   end
   initial begin
      t_lines;
      t_arb(1'h0);
      t_arb(1'h1);
      t_host;
      t_ack(1'h0);
      t_ack(1'h1);
      t_cpa;
      finish_test;
   end
endmodule : test_multiproc_bus_arbitration_host_ack
